// ==== design/sssp_pkg.sv ====
package sssp_pkg;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [11:0] SSSP_IDX_IRQ = 12'h003;
	localparam logic [11:0] SSSP_IDX_MODE = 12'h005;
	localparam logic [11:0] SSSP_IDX_DLO = 12'h006;
	localparam logic [11:0] SSSP_IDX_DHI = 12'h007;
	localparam logic [11:0] SSSP_IDX_PINF = 12'h004;
	localparam logic [11:0] SSSP_IDX_IE = 12'h000;
	localparam logic [11:0] SSSP_ADDR_IRQ = 12'h00c;
	localparam logic [11:0] SSSP_ADDR_MODE = 12'h014;
	localparam logic [11:0] SSSP_ADDR_DLO = 12'h018;
	localparam logic [11:0] SSSP_ADDR_DHI = 12'h01c;
	localparam logic [11:0] SSSP_ADDR_PINF = 12'h010;
	localparam logic [11:0] SSSP_ADDR_IE = 12'h000;
	// field positions
	localparam int SSSP_FLAG_BIT = 0;
	localparam int SSSP_MASK_BIT = 1;
	localparam int SSSP_PIN_BIT = 3;
	localparam int SSSP_DIN_BIT = 1;
	localparam int SSSP_DOUT_BIT = 0;
	// reset values
	localparam logic [3:0] SSSP_MODE_RST = 4'h0;
	localparam logic [3:0] SSSP_PINF_RST = 4'h0;
	localparam logic SSSP_MASK_RST = 1'b1;
	// mode register write takes effect this many cycles later
	localparam logic [1:0] SSSP_MODE_DELAY = 2'h2;
	// clock source codes
	localparam logic [2:0] SSSP_SRC_SYS = 3'h6;
	localparam logic [2:0] SSSP_SRC_EXT = 3'h7;
	localparam logic [2:0] SSSP_BITS_LAST = 3'h7;
	localparam logic [11:0] SSSP_DIV_MAX = 12'hfff;
	typedef enum logic [1:0] {SSSP_WAIT_START, SSSP_WAIT_CLK, SSSP_XFER} sssp_state_e;
endpackage

// ==== design/sssp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sssp_top
	import sssp_pkg::*;
#(
	parameter int DIV_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_shift_cmd,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe,
	output logic clk_pin_serial,
	output logic data_in_pin_serial,
	output logic serial_irq_req
);
	// apb decode
	logic wr_en, rd_en;
	logic [3:0] mode_q, mode_pend_q, pinf_q;
	logic [1:0] mode_dly_q;
	logic mode_wr;
	logic flag_q, mask_q, gie_q;
	logic [7:0] shreg_q;
	logic [2:0] cnt_q;
	sssp_state_e state_q;
	logic sck_s1_q, sck_s2_q, sck_s3_q;
	logic [DIV_W-1:0] div_q;
	logic gen_q, gen_run_q;
	logic [3:0] gen_cnt_q;
	logic ser_clk, fall_ev, rise_ev, ext_sel;
	logic [11:0] div_lim;
	logic pinf_chg;
	logic abort_ev, wrap_ev;

	// strobes qualified to the access phase only; the slave never stalls,
	// so an access phase lasts one cycle and these pulse exactly once
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign mode_wr = wr_en & (paddr == SSSP_ADDR_MODE);
	assign pinf_chg = wr_en & (paddr == SSSP_ADDR_PINF) & (pwdata[1:0] != pinf_q[1:0]);

	// zero-wait slave, errors on unmapped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel & ~penable)
			begin
				unique case (paddr)
					SSSP_ADDR_IRQ: prdata <= {30'h0, mask_q, flag_q};
					SSSP_ADDR_DLO: prdata <= {28'h0, shreg_q[3:0]};
					SSSP_ADDR_DHI: prdata <= {28'h0, shreg_q[7:4]};
					SSSP_ADDR_IE: prdata <= {31'h0, gie_q};
					SSSP_ADDR_MODE, SSSP_ADDR_PINF: prdata <= 32'h0; // write-only
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// write-only mode register with two-cycle delayed effect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= SSSP_MODE_RST;
			mode_pend_q <= SSSP_MODE_RST;
			mode_dly_q <= 2'h0;
		end
		else if (mode_wr & pready)
		begin
			mode_pend_q <= pwdata[3:0];
			mode_dly_q <= SSSP_MODE_DELAY;
		end
		else if (mode_dly_q != 2'h0)
		begin
			mode_dly_q <= mode_dly_q - 2'h1;
			if (mode_dly_q == 2'h1)
				mode_q <= mode_pend_q;
		end
	end

	// pin function and global enable registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pinf_q <= SSSP_PINF_RST;
			gie_q <= 1'b0;
		end
		else if (wr_en & pready)
		begin
			if (paddr == SSSP_ADDR_PINF)
				pinf_q <= pwdata[3:0];
			if (paddr == SSSP_ADDR_IE)
				gie_q <= pwdata[0];
		end
	end

	// external clock synchroniser and edge detect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_s3_q <= 1'b1;
		end
		else
		begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
		end
	end

	// divide limit: half period minus one in system clocks
	always_comb
	begin
		unique case (mode_q[2:0])
			3'h0: div_lim = 12'h7ff;
			3'h1: div_lim = 12'h1ff;
			3'h2: div_lim = 12'h07f;
			3'h3: div_lim = 12'h01f;
			3'h4: div_lim = 12'h007;
			3'h5: div_lim = 12'h001;
			default: div_lim = 12'h000;
		endcase
	end

	assign ext_sel = (mode_q[2:0] == SSSP_SRC_EXT);

	// internal clock generator, eight periods per start or free run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= '0;
			gen_q <= 1'b1;
			gen_run_q <= 1'b0;
			gen_cnt_q <= 4'h0;
		end
		else if (mode_wr)
		begin
			gen_run_q <= 1'b0;
			gen_q <= 1'b1;
			div_q <= '0;
		end
		else if (start_shift_cmd & ~ext_sel & mode_q[SSSP_PIN_BIT])
		begin
			gen_run_q <= 1'b1;
			gen_cnt_q <= 4'h0;
			div_q <= '0;
			gen_q <= 1'b1;
		end
		else if (gen_run_q)
		begin
			if ((mode_q[2:0] == SSSP_SRC_SYS) || (div_q == div_lim[DIV_W-1:0]))
			begin
				div_q <= '0;
				gen_q <= ~gen_q;
				if (!gen_q)
				begin
					gen_cnt_q <= gen_cnt_q + 4'h1;
					if ((gen_cnt_q == 4'h7) && (pinf_q[1:0] != 2'h0))
						gen_run_q <= 1'b0;
				end
			end
			else
				div_q <= div_q + 1'b1;
		end
	end

	assign ser_clk = ext_sel ? sck_s2_q : gen_q;
	assign fall_ev = ext_sel ? (sck_s3_q & ~sck_s2_q) : (gen_run_q & gen_q & ((mode_q[2:0] == SSSP_SRC_SYS) || (div_q == div_lim[DIV_W-1:0])));
	assign rise_ev = ext_sel ? (~sck_s3_q & sck_s2_q) : (gen_run_q & ~gen_q & ((mode_q[2:0] == SSSP_SRC_SYS) || (div_q == div_lim[DIV_W-1:0])));
	// abort: counter cleared by a mode write or a start while a frame runs
	assign abort_ev = (mode_wr | start_shift_cmd) & (state_q == SSSP_XFER);
	// wrap: eighth rising edge of the frame
	assign wrap_ev = (state_q == SSSP_XFER) & rise_ev & (cnt_q == SSSP_BITS_LAST);

	// operating state machine and counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= SSSP_WAIT_START;
			cnt_q <= 3'h0;
		end
		else if (mode_wr | pinf_chg)
		begin
			state_q <= SSSP_WAIT_START;
			cnt_q <= 3'h0;
		end
		else if (start_shift_cmd)
		begin
			cnt_q <= 3'h0;
			state_q <= SSSP_WAIT_CLK;
		end
		else
		begin
			unique case (state_q)
				SSSP_WAIT_START: cnt_q <= 3'h0;
				SSSP_WAIT_CLK:
				begin
					if (fall_ev && pinf_q[1:0] != 2'h0)
						state_q <= SSSP_XFER;
				end
				SSSP_XFER:
				begin
					if (rise_ev)
					begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == SSSP_BITS_LAST)
							state_q <= SSSP_WAIT_CLK;
					end
				end
			endcase
		end
	end

	// shift register: lsb out on falling, lsb-first sample into msb on rising
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shreg_q <= 8'h0;
		else if (wr_en & pready & (paddr == SSSP_ADDR_DLO))
			shreg_q[3:0] <= pwdata[3:0];
		else if (wr_en & pready & (paddr == SSSP_ADDR_DHI))
			shreg_q[7:4] <= pwdata[3:0];
		else if ((state_q == SSSP_XFER) & rise_ev)
			shreg_q <= {sdi_in, shreg_q[7:1]};
	end

	// data-out latch: outside start-wait the next bit appears only on a serial falling edge,
	// so the pin stays put across the rising edge where the peer samples
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sdo_out <= 1'b1;
		else if (fall_ev && (state_q != SSSP_WAIT_START))
			sdo_out <= shreg_q[0];
		else if (state_q == SSSP_WAIT_START)
			sdo_out <= shreg_q[0]; // idle: show the first bit to go
	end

	// flag and mask: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_q <= 1'b0;
			mask_q <= SSSP_MASK_RST;
		end
		else
		begin
			if (wrap_ev | abort_ev)
				flag_q <= 1'b1;
			else if (wr_en & pready & (paddr == SSSP_ADDR_IRQ))
				flag_q <= pwdata[SSSP_FLAG_BIT];
			if (wr_en & pready & (paddr == SSSP_ADDR_IRQ))
				mask_q <= pwdata[SSSP_MASK_BIT];
		end
	end

	// registered pin drive and request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
			sdo_oe <= 1'b0;
			clk_pin_serial <= 1'b0;
			data_in_pin_serial <= 1'b0;
			serial_irq_req <= 1'b0;
		end
		else
		begin
			sck_out <= gen_q;
			sck_oe <= mode_q[SSSP_PIN_BIT] & ~ext_sel;
			clk_pin_serial <= mode_q[SSSP_PIN_BIT];
			sdo_oe <= pinf_q[SSSP_DOUT_BIT];
			data_in_pin_serial <= pinf_q[SSSP_DIN_BIT];
			serial_irq_req <= flag_q & ~mask_q & gie_q;
		end
	end

	// unused level kept for reference of active clock
	logic unused_clk;
	assign unused_clk = ser_clk;

	// flag sets within one cycle of a counter wrap
	wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap_ev |=> flag_q) else $error("flag not set on wrap");
	// mode write clears counter and returns to start-wait
	mode_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode_wr |=> (cnt_q == 3'h0) && (state_q == SSSP_WAIT_START)) else $error("mode write bad");
	// start clears counter, enters clock-wait
	start_go_a: assert property (@(posedge pclk) disable iff (!presetn)
		start_shift_cmd && !mode_wr && !pinf_chg |=> state_q == SSSP_WAIT_CLK && cnt_q == 3'h0) else $error("start bad");
	// start-wait ignores clocks
	idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SSSP_WAIT_START && !start_shift_cmd |=> state_q == SSSP_WAIT_START) else $error("left start-wait");
	// mode takes effect two cycles after write
	mode_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode_wr && pready ##1 !mode_wr[*2] |=> mode_q == $past(pwdata[3:0], 3)) else $error("mode delay bad");
	// request only with flag, unmasked, enabled
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		serial_irq_req |-> $past(flag_q && !mask_q && gie_q)) else $error("irq gate bad");
	// counter advances by one on each rising edge in transfer
	cnt_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SSSP_XFER && rise_ev && !mode_wr && !pinf_chg && !start_shift_cmd
		|=> cnt_q == $past(cnt_q) + 3'h1) else $error("count step bad");
	// continuous mode never enters transfer
	cont_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SSSP_WAIT_CLK && pinf_q[1:0] == 2'h0 && !mode_wr && !pinf_chg |=> state_q != SSSP_XFER) else $error("continuous left wait");
	// data out holds between serial falling edges during a frame
	sdo_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SSSP_XFER && !fall_ev |=> $stable(sdo_out)) else $error("data out moved off edge");
	// an aborted frame raises the flag
	abort_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		abort_ev |=> flag_q) else $error("flag not set on abort");
endmodule
`default_nettype wire

// ==== tb/sssp_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module sssp_peer
(
	input wire logic pclk,
	input wire logic go,
	input wire logic [7:0] tx_byte,
	input wire logic [3:0] n_clk,
	input wire logic sdo_out,
	output logic sck_in,
	output logic sdi_in,
	output logic [7:0] rx_byte,
	output logic busy
);
	int i;
	// serial clock idles high between frames
	initial
	begin
		sck_in = 1'b1;
		sdi_in = 1'b0;
		rx_byte = 8'h00;
		busy = 1'b0;
	end
	// one frame of n_clk clocks, half period of eight system clocks
	always @(posedge pclk)
	begin
		if (go && !busy)
		begin
			busy <= 1'b1;
			for (i = 0; i < n_clk; i++)
			begin
				repeat (8) @(posedge pclk);
				sck_in <= 1'b0;
				sdi_in <= tx_byte[7 - i[2:0]];
				repeat (8) @(posedge pclk);
				sck_in <= 1'b1;
				rx_byte <= {sdo_out, rx_byte[7:1]};
			end
			repeat (8) @(posedge pclk);
			// released line shows the inverse of the last bit
			sdi_in <= ~sdi_in;
			busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
import sssp_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, start_shift_cmd, go, pbusy, sck_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, perr, sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe;
	logic clk_pin_serial, data_in_pin_serial, serial_irq_req;
	logic [7:0] ptx, prx, mon;
	logic [3:0] pn;
	int n_fail, compares, cyc, nfall;
	sssp_top sssp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_shift_cmd(start_shift_cmd), .sck_in(sck_in),
		.sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .clk_pin_serial(clk_pin_serial),
		.data_in_pin_serial(data_in_pin_serial), .serial_irq_req(serial_irq_req));
	sssp_peer sssp_peer_inst (.pclk(pclk), .go(go), .tx_byte(ptx), .n_clk(pn),
		.sdo_out(sdo_out), .sck_in(sck_in), .sdi_in(sdi_in), .rx_byte(prx), .busy(pbusy));
	// clock, 5 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// generated clock watcher: counts falls, gathers output bits on rises
	always @(posedge pclk)
	begin
		sck_q <= sck_out;
		cyc <= cyc + 1;
		if (sck_q && !sck_out && sck_oe)
			nfall <= nfall + 1;
		if (!sck_q && sck_out)
			mon <= {sdo_out, mon[7:1]};
		if (cyc == 20000)
		begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out();
		$display("n_fail %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		if (g !== e)
			n_fail++;
	endtask
	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse_start();
		@(posedge pclk);
		start_shift_cmd <= 1'b1;
		@(posedge pclk);
		start_shift_cmd <= 1'b0;
	endtask
	// peer frame of n clocks, waits hold cycles, then waits for its end only when hold is under 8
	task automatic frame(input logic [7:0] b, input logic [3:0] n, input int hold);
		int k;
		ptx <= b;
		pn <= n;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (hold) @(posedge pclk);
		for (k = 0; hold < 8 && k < 400 && pbusy !== 1'b0; k++)
			@(posedge pclk);
	endtask
	task automatic set_mode(input logic [3:0] m);
		apb(1'b1, SSSP_ADDR_MODE, {28'h0, m});
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_reset();
		apb(1'b0, SSSP_ADDR_MODE, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, SSSP_ADDR_IRQ, 32'h0);
		chk(rdat[3:0], 4'h2);
		apb(1'b0, 12'h020, 32'h0);
		chk(perr, 1'b1);
		apb(1'b1, SSSP_ADDR_IE, 32'h1);
		apb(1'b1, SSSP_ADDR_PINF, 32'h3);
		repeat (2) @(posedge pclk);
		chk({data_in_pin_serial, sdo_oe}, 2'h3);
	endtask
	task automatic t_internal();
		int k;
		apb(1'b1, SSSP_ADDR_DLO, 32'h5);
		apb(1'b1, SSSP_ADDR_DHI, 32'ha);
		set_mode(4'hd);
		chk(clk_pin_serial, 1'b1);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h0);
		nfall = 0;
		pulse_start();
		for (k = 0; k < 300 && serial_irq_req !== 1'b1; k++)
			@(posedge pclk);
		repeat (20) @(posedge pclk);
		chk(nfall, 8);
		chk(mon, 8'ha5);
		chk(serial_irq_req, 1'b1);
	endtask
	task automatic t_external();
		set_mode(4'hf);
		apb(1'b1, SSSP_ADDR_DLO, 32'h6);
		apb(1'b1, SSSP_ADDR_DHI, 32'h9);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h0);
		pulse_start();
		frame(8'h3c, 4'h8, 4);
		apb(1'b0, SSSP_ADDR_DLO, 32'h0);
		mon = {4'h0, rdat[3:0]};
		apb(1'b0, SSSP_ADDR_DHI, 32'h0);
		chk({rdat[3:0], mon[3:0]}, 8'h3c);
		chk(prx, 8'h96);
		apb(1'b0, SSSP_ADDR_IRQ, 32'h0);
		chk(rdat[0], 1'b1);
	endtask
	task automatic t_abort();
		apb(1'b1, SSSP_ADDR_IRQ, 32'h0);
		pulse_start();
		frame(8'h55, 4'h8, 40);
		chk(pbusy, 1'b1);
		apb(1'b1, SSSP_ADDR_MODE, 32'hf);
		apb(1'b0, SSSP_ADDR_IRQ, 32'h0);
		chk(rdat[0], 1'b1);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h0);
		frame(8'h55, 4'h8, 4);
		apb(1'b0, SSSP_ADDR_IRQ, 32'h0);
		chk(rdat[0], 1'b0);
	endtask
	task automatic t_extra();
		pulse_start();
		frame(8'hf0, 4'h9, 4);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h0);
		apb(1'b1, SSSP_ADDR_MODE, 32'hf);
		apb(1'b0, SSSP_ADDR_IRQ, 32'h0);
		chk(rdat[0], 1'b1);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h3);
		repeat (2) @(posedge pclk);
		chk(serial_irq_req, 1'b0);
		apb(1'b1, SSSP_ADDR_IRQ, 32'h1);
		apb(1'b1, SSSP_ADDR_IE, 32'h0);
		repeat (2) @(posedge pclk);
		chk(serial_irq_req, 1'b0);
	endtask
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, start_shift_cmd, go, sck_q} = 7'h0;
		{paddr, pwdata, ptx, pn, mon} = '0;
		{n_fail, compares, cyc, nfall} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_internal();
		t_external();
		t_abort();
		t_extra();
		close_out();
	end
endmodule
`default_nettype wire
